// ### src/adc_ctl_pkg.sv
// Constants shared by the converter cycle controller and its helpers.
// Assumes a 100 MHz system clock; the serial clock pin may run up to 4 MHz.
package adc_ctl_pkg;

  // ==========================================================================
  // Clock rates and derived cycle counts
  // ==========================================================================
  localparam int unsigned SYS_CLK_HZ    = 100_000_000;
  localparam int unsigned INT_OSC_HZ    = 307_200;
  localparam int unsigned INT_SCK_HZ    = 38_400;
  localparam int unsigned INT_OSC_DIV   = SYS_CLK_HZ / INT_OSC_HZ;
  localparam int unsigned ISCK_HALF     = SYS_CLK_HZ / (2 * INT_SCK_HZ);
  localparam int unsigned EXT_OSC_IDLE  = 2 * INT_OSC_DIV;
  localparam int unsigned CONV_TICKS_DEF = 10280;

  // ==========================================================================
  // Frame geometry
  // ==========================================================================
  localparam int unsigned RESULT_BITS   = 24;
  localparam int unsigned CFG_BITS      = 8;

  // ==========================================================================
  // Configuration word fields, first bit shifted in is bit 7
  // ==========================================================================
  localparam int unsigned CFG_EN_POS    = 7;
  localparam int unsigned CFG_GAIN_MSB  = 6;
  localparam int unsigned CFG_GAIN_LSB  = 4;
  localparam int unsigned CFG_IM_POS    = 3;
  localparam int unsigned CFG_REJ_MSB   = 2;
  localparam int unsigned CFG_REJ_LSB   = 1;
  localparam int unsigned CFG_SPD_POS   = 0;
  localparam logic [2:0]  GAIN_DEF      = 3'h0;
  localparam logic [1:0]  REJ_DEF       = 2'h0;
  localparam logic [1:0]  REJ_RESERVED  = 2'h3;

  // ==========================================================================
  // Serial output status levels
  // ==========================================================================
  localparam logic        STAT_BUSY     = 1'b1;
  localparam logic        STAT_READY    = 1'b0;

  typedef enum logic [1:0] {
    ST_CONV  = 2'h0,
    ST_SLEEP = 2'h1,
    ST_OUT   = 2'h3
  } cycle_state_e;

endpackage

// ### src/adc_serial_cycle_control.sv
// Conversion, sleep and data output cycle with its four-wire serial port.
// Assumes the analog core presents a settled result when a conversion ends
// and that the serial clock wire level is resolved outside from the enables.
`timescale 1ns/100ps
module adc_serial_cycle_control #(
  parameter int unsigned CONV_TICKS = adc_ctl_pkg::CONV_TICKS_DEF
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        serial_clock_in,
  output logic             serial_clock_out,
  output logic             serial_clock_oe_out,
  output logic             serial_clock_pullup_out,
  input  wire logic        chip_select_n_in,
  input  wire logic        serial_in_in,
  output logic             serial_out_out,
  output logic             serial_out_oe_out,
  input  wire logic        conversion_clock_select_in,
  input  wire logic [15:0] result_value_in,
  input  wire logic        result_sign_in,
  input  wire logic        result_over_in,
  input  wire logic        result_under_in,
  output logic [2:0]       gain_code_out,
  output logic             temp_input_out,
  output logic [1:0]       rejection_mode_out,
  output logic             autocal_en_out,
  output logic             convert_start_out,
  output logic             sleep_out,
  output logic             internal_sck_mode_out
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [2:0] pins_s;
  logic       sck_s;
  logic       cs_n_s;
  logic       fclk_s;

  cdc_sync #(
    .WIDTH    (3)
  ) u_pin_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    // Select crosses inverted so the cleared stages match its idle level
    .async_in ({serial_clock_in, !chip_select_n_in, conversion_clock_select_in}),
    .sync_out (pins_s)
  );

  assign sck_s  = pins_s[2];
  assign cs_n_s = !pins_s[1];
  assign fclk_s = pins_s[0];

  logic sck_d_r;
  logic cs_n_d_r;
  logic fclk_d_r;
  logic started_r;
  logic primed_r;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      sck_d_r   <= 1'b0;
      cs_n_d_r  <= 1'b1;
      fclk_d_r  <= 1'b0;
      started_r <= 1'b0;
      primed_r  <= 1'b0;
    end
    else
    begin
      sck_d_r   <= sck_s;
      cs_n_d_r  <= cs_n_s;
      fclk_d_r  <= fclk_s;
      started_r <= 1'b1;
      primed_r  <= started_r;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic fclk_rise;

  assign sck_rise  = started_r && sck_s && !sck_d_r;
  assign sck_fall  = started_r && !sck_s && sck_d_r;
  assign cs_fall   = started_r && !cs_n_s && cs_n_d_r;
  assign cs_rise   = started_r && cs_n_s && !cs_n_d_r;
  assign fclk_rise = started_r && fclk_s && !fclk_d_r;

  // ==========================================================================
  // Serial clock mode
  // ==========================================================================
  logic int_mode_r;
  logic mode_caught_r;

  // Caught once the synchroniser holds a real pin level, not its cleared value
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      int_mode_r    <= 1'b0;
      mode_caught_r <= 1'b0;
    end
    else if (primed_r && !mode_caught_r)
    begin
      int_mode_r    <= !sck_s;
      mode_caught_r <= 1'b1;
    end
    else if (cs_fall)
    begin
      int_mode_r <= !sck_s;
    end
  end

  // ==========================================================================
  // Conversion clock source
  // ==========================================================================
  logic [15:0] osc_cnt_r;
  logic [15:0] idle_cnt_r;
  logic        ext_osc_r;
  logic        int_tick_r;
  logic        conv_tick;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      osc_cnt_r  <= 16'h0000;
      int_tick_r <= 1'b0;
    end
    else if (osc_cnt_r == 16'(adc_ctl_pkg::INT_OSC_DIV - 1))
    begin
      osc_cnt_r  <= 16'h0000;
      int_tick_r <= 1'b1;
    end
    else
    begin
      osc_cnt_r  <= osc_cnt_r + 16'h0001;
      int_tick_r <= 1'b0;
    end
  end

  // A pin with recent edges is an external oscillator; a quiet pin is ground
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      idle_cnt_r <= 16'h0000;
      ext_osc_r  <= 1'b0;
    end
    else if (fclk_rise)
    begin
      idle_cnt_r <= 16'h0000;
      ext_osc_r  <= 1'b1;
    end
    else if (idle_cnt_r == 16'(adc_ctl_pkg::EXT_OSC_IDLE))
    begin
      ext_osc_r <= 1'b0;
    end
    else
    begin
      idle_cnt_r <= idle_cnt_r + 16'h0001;
    end
  end

  assign conv_tick = ext_osc_r ? fclk_rise : int_tick_r;

  // ==========================================================================
  // Link domain: configuration capture on the serial clock
  // ==========================================================================
  logic       frame_tag_r;
  logic       seen_tag_r;
  logic [3:0] cfg_idx_r;
  logic [7:0] cfg_shift_r;

  // Frame tag settles in the system domain well before the first rising
  // serial clock; it stays static for the whole frame
  always_ff @(posedge serial_clock_in)
  begin
    if (seen_tag_r == frame_tag_r)
    begin
      if (cfg_idx_r < 4'(adc_ctl_pkg::CFG_BITS))
      begin
        cfg_shift_r[3'(7 - cfg_idx_r)] <= serial_in_in;
        cfg_idx_r                      <= cfg_idx_r + 4'h1;
      end
    end
    else
    begin
      // Also settles the unreset flops at their first edge
      seen_tag_r  <= frame_tag_r;
      cfg_idx_r   <= 4'h1;
      cfg_shift_r <= {serial_in_in, 7'h00};
    end
  end

  // Word is static once the frame ends, so a level crossing suffices
  logic [7:0] cfg_s;
  logic       seen_tag_s;

  cdc_sync #(
    .WIDTH    (9)
  ) u_cfg_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n_in),
    .async_in ({seen_tag_r, cfg_shift_r}),
    .sync_out ({seen_tag_s, cfg_s})
  );

  // ==========================================================================
  // Configuration
  // ==========================================================================
  logic [2:0] gain_r;
  logic       temp_r;
  logic [1:0] rej_r;
  logic       speed_r;
  logic       apply_cfg;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      gain_r  <= adc_ctl_pkg::GAIN_DEF;
      temp_r  <= 1'b0;
      rej_r   <= adc_ctl_pkg::REJ_DEF;
      speed_r <= 1'b0;
    end
    else if (apply_cfg && seen_tag_s == frame_tag_r && cfg_s[adc_ctl_pkg::CFG_EN_POS])
    begin
      gain_r  <= cfg_s[adc_ctl_pkg::CFG_GAIN_MSB:adc_ctl_pkg::CFG_GAIN_LSB];
      temp_r  <= cfg_s[adc_ctl_pkg::CFG_IM_POS];
      speed_r <= cfg_s[adc_ctl_pkg::CFG_SPD_POS];
      // Reserved code is the host's to avoid; it is passed through as is
      rej_r   <= cfg_s[adc_ctl_pkg::CFG_REJ_MSB:adc_ctl_pkg::CFG_REJ_LSB];
    end
  end

  logic [2:0] eff_gain;
  logic       eff_speed;

  assign eff_gain  = temp_r ? adc_ctl_pkg::GAIN_DEF : gain_r;
  assign eff_speed = temp_r ? 1'b0 : speed_r;

  // ==========================================================================
  // Cycle state machine
  // ==========================================================================
  adc_ctl_pkg::cycle_state_e state_r;
  adc_ctl_pkg::cycle_state_e state_nxt;
  logic                      conv_start_r;
  logic                      phase_start;
  logic                      conv_done;
  logic                      conv_busy;
  logic                      rise_seen_r;
  logic [4:0]                fall_cnt_r;
  logic                      out_done;

  conv_timer #(
    .TICKS           (CONV_TICKS)
  ) u_timer (
    .clk_in          (clk_sys_in),
    .rst_n_in        (rst_n_in),
    .tick_in         (conv_tick),
    .start_in        (conv_start_r),
    .two_phase_in    (!eff_speed),
    .phase_start_out (phase_start),
    .done_out        (conv_done),
    .busy_out        (conv_busy)
  );

  assign out_done = sck_fall && fall_cnt_r == 5'(adc_ctl_pkg::RESULT_BITS - 1);

  always_comb
  begin
    state_nxt = state_r;
    apply_cfg = 1'b0;
    case (state_r)
      adc_ctl_pkg::ST_CONV:
      begin
        if (conv_done)
        begin
          state_nxt = adc_ctl_pkg::ST_SLEEP;
        end
      end
      adc_ctl_pkg::ST_SLEEP:
      begin
        if (!cs_n_s)
        begin
          state_nxt = adc_ctl_pkg::ST_OUT;
        end
      end
      adc_ctl_pkg::ST_OUT:
      begin
        if (cs_rise && !rise_seen_r)
        begin
          state_nxt = adc_ctl_pkg::ST_SLEEP;
        end
        else if (cs_rise || out_done)
        begin
          state_nxt = adc_ctl_pkg::ST_CONV;
          apply_cfg = 1'b1;
        end
      end
      default:
      begin
        state_nxt = adc_ctl_pkg::ST_CONV;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_r      <= adc_ctl_pkg::ST_CONV;
      conv_start_r <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      // First conversion starts right after reset
      conv_start_r <= (state_r == adc_ctl_pkg::ST_CONV && !conv_busy && !conv_start_r && !conv_done)
                      || (state_r == adc_ctl_pkg::ST_OUT && state_nxt == adc_ctl_pkg::ST_CONV);
    end
  end

  // New frame marker for the link domain
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      frame_tag_r <= 1'b0;
    end
    // A frame closed before any clock edge is undone, else the link side
    // would see the next frame's tag as already taken
    else if ((state_r == adc_ctl_pkg::ST_SLEEP && state_nxt == adc_ctl_pkg::ST_OUT)
             || (state_r == adc_ctl_pkg::ST_OUT && state_nxt == adc_ctl_pkg::ST_SLEEP))
    begin
      frame_tag_r <= !frame_tag_r;
    end
  end

  // ==========================================================================
  // Result shift register
  // ==========================================================================
  logic [23:0] result_r;

  // Over and underrange use codes no in-range value can produce
  function automatic logic [23:0] result_word(input logic        over,
                                              input logic        under,
                                              input logic        sign,
                                              input logic [15:0] value);
    if (over)
    begin
      result_word = {2'h0, 1'b1, 1'b1, 16'h0000, 4'h0};
    end
    else if (under)
    begin
      result_word = {2'h0, 1'b0, 1'b1, 16'hffff, 4'h0};
    end
    else
    begin
      result_word = {2'h0, sign, 1'b0, value, 4'h0};
    end
  endfunction

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      result_r    <= 24'h000000;
      rise_seen_r <= 1'b0;
      fall_cnt_r  <= 5'h00;
    end
    else if (state_r == adc_ctl_pkg::ST_CONV && conv_done)
    begin
      result_r <= result_word(result_over_in, result_under_in, result_sign_in, result_value_in);
    end
    else if (state_r == adc_ctl_pkg::ST_OUT)
    begin
      if (sck_rise)
      begin
        rise_seen_r <= 1'b1;
      end
      if (sck_fall && rise_seen_r)
      begin
        result_r   <= {result_r[22:0], 1'b0};
        fall_cnt_r <= fall_cnt_r + 5'h01;
      end
    end
    else
    begin
      // Sleep leaves the result untouched
      rise_seen_r <= 1'b0;
      fall_cnt_r  <= 5'h00;
    end
  end

  // ==========================================================================
  // Internal serial clock generator
  // ==========================================================================
  logic [11:0] isck_cnt_r;
  logic        isck_run;

  assign isck_run = int_mode_r && state_r == adc_ctl_pkg::ST_OUT && !cs_n_s;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      isck_cnt_r       <= 12'h000;
      serial_clock_out <= 1'b0;
    end
    else if (!isck_run)
    begin
      isck_cnt_r       <= 12'h000;
      serial_clock_out <= 1'b0;
    end
    else if (isck_cnt_r == 12'(adc_ctl_pkg::ISCK_HALF - 1))
    begin
      isck_cnt_r       <= 12'h000;
      serial_clock_out <= !serial_clock_out;
    end
    else
    begin
      isck_cnt_r <= isck_cnt_r + 12'h001;
    end
  end

  // ==========================================================================
  // Pin drivers and status outputs
  // ==========================================================================
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      serial_out_out          <= 1'b0;
      serial_out_oe_out       <= 1'b0;
      serial_clock_oe_out     <= 1'b0;
      serial_clock_pullup_out <= 1'b0;
      internal_sck_mode_out   <= 1'b0;
      gain_code_out           <= adc_ctl_pkg::GAIN_DEF;
      temp_input_out          <= 1'b0;
      rejection_mode_out      <= adc_ctl_pkg::REJ_DEF;
      autocal_en_out          <= 1'b1;
      convert_start_out       <= 1'b0;
      sleep_out               <= 1'b0;
    end
    else
    begin
      serial_out_oe_out <= !cs_n_s;
      case (state_r)
        adc_ctl_pkg::ST_CONV:  serial_out_out <= adc_ctl_pkg::STAT_BUSY;
        adc_ctl_pkg::ST_SLEEP: serial_out_out <= adc_ctl_pkg::STAT_READY;
        default:               serial_out_out <= result_r[23];
      endcase
      serial_clock_oe_out     <= isck_run;
      serial_clock_pullup_out <= int_mode_r;
      internal_sck_mode_out   <= int_mode_r;
      gain_code_out           <= eff_gain;
      temp_input_out          <= temp_r;
      rejection_mode_out      <= rej_r;
      autocal_en_out          <= !eff_speed;
      convert_start_out       <= phase_start;
      // Wakes on the same edge the state leaves sleep, not a cycle after it
      sleep_out               <= state_r == adc_ctl_pkg::ST_SLEEP && cs_n_s;
    end
  end

endmodule // adc_serial_cycle_control

// ### src/cdc_sync.sv
// Two-stage level synchroniser, one lane per bit.
// Assumes each input bit is a level that stays put for several clocks.
`timescale 1ns/100ps
module cdc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic [WIDTH-1:0] meta_r;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_lane
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          meta_r[gi]   <= 1'b0;
          sync_out[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi]   <= async_in[gi];
          sync_out[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule // cdc_sync

// ### src/conv_timer.sv
// Times one conversion cycle as one or two internal conversions.
// Assumes tick_in is a one-cycle pulse per conversion clock period.
`timescale 1ns/100ps
module conv_timer #(
  parameter int unsigned TICKS = 10280
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic tick_in,
  input  wire logic start_in,
  input  wire logic two_phase_in,
  output logic      phase_start_out,
  output logic      done_out,
  output logic      busy_out
);

  // ==========================================================================
  // Tick counter
  // ==========================================================================
  logic [15:0] cnt_r;
  logic        second_r;
  logic        two_r;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r           <= 16'h0000;
      second_r        <= 1'b0;
      two_r           <= 1'b0;
      busy_out        <= 1'b0;
      done_out        <= 1'b0;
      phase_start_out <= 1'b0;
    end
    else
    begin
      done_out        <= 1'b0;
      phase_start_out <= 1'b0;
      if (start_in)
      begin
        cnt_r           <= 16'h0000;
        second_r        <= 1'b0;
        two_r           <= two_phase_in;
        busy_out        <= 1'b1;
        phase_start_out <= 1'b1;
      end
      else if (busy_out && tick_in)
      begin
        if (cnt_r == 16'(TICKS - 1))
        begin
          cnt_r <= 16'h0000;
          // Offset cancelled by pairing two conversions
          if (two_r && !second_r)
          begin
            second_r        <= 1'b1;
            phase_start_out <= 1'b1;
          end
          else
          begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
        else
        begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

endmodule // conv_timer

// ### verification/adc_host_model.sv
// Host side of the serial port: external serial clock, config word out.
// Assumes a free link clock; the serial clock is set before select and toggles only inside frames.
`timescale 1ns/100ps
module adc_host_model (
  input  wire logic clk_link_in,
  input  wire logic sdo_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      sdi_out
);
  // Low at power-up, so the device starts in internal clock mode
  initial sck_out = 1'b0;
  initial cs_n_out = 1'b1;
  initial sdi_out = 1'b0;
  // ====
  // Frame
  task automatic half();
    repeat (4) @(posedge clk_link_in); // 128 ns, just above the 125 ns minimum
  endtask
  task automatic frame(input logic [7:0] cfg, input int n, output logic [23:0] rx);
    rx = 24'h0;
    sck_out <= 1'b1;
    half();
    cs_n_out <= 1'b0;
    half();
    for (int i = 0; i < n; i++)
    begin
      sck_out <= 1'b0;
      sdi_out <= (i < 8) ? cfg[7-i] : 1'b0;
      half();
      sck_out <= 1'b1;
      half();
      rx = {rx[22:0], sdo_in};
    end
    cs_n_out <= 1'b1;
    half();
  endtask
  // Internal clock frame: clock held low at select, device drives it
  task automatic select_internal();
    sck_out <= 1'b0;
    half();
    cs_n_out <= 1'b0;
  endtask
  task automatic deselect();
    cs_n_out <= 1'b1;
    half();
  endtask
endmodule // adc_host_model

// ### verification/adc_serial_cycle_control_checker.sv
// Port assertions for the converter cycle controller.
// Assumes it is bound into adc_serial_cycle_control.
`timescale 1ns/100ps
module adc_serial_cycle_control_checker #(
  parameter int unsigned CONV_TICKS = 4
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic serial_clock_in,
  input  wire logic serial_clock_oe_out,
  input  wire logic serial_clock_pullup_out,
  input  wire logic chip_select_n_in,
  input  wire logic serial_out_out,
  input  wire logic serial_out_oe_out,
  input  wire logic autocal_en_out,
  input  wire logic convert_start_out,
  input  wire logic sleep_out,
  input  wire logic internal_sck_mode_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ====
  // Helpers: transfer under way, starts since last sleep
  logic       xfer_r;
  logic [2:0] starts_r;
  always_ff @(posedge clk_sys_in)
    xfer_r <= rst_n_in && !chip_select_n_in && (xfer_r || $rose(serial_clock_in));
  always_ff @(posedge clk_sys_in)
    starts_r <= (!rst_n_in || sleep_out) ? 3'h0 : starts_r + {2'h0, convert_start_out};
  sequence s_wake;
    sleep_out ##1 !sleep_out && !chip_select_n_in;
  endsequence
  // ====
  // Assertions
  a_out_released: assert property (chip_select_n_in [*5] |-> !serial_out_oe_out)
    else $error("serial out driven while deselected");
  a_out_enabled: assert property (!chip_select_n_in [*5] |-> serial_out_oe_out)
    else $error("serial out not enabled under select");
  a_sleep_status: assert property (s_wake |-> serial_out_oe_out && serial_out_out == 1'b0)
    else $error("wrong status while waking");
  a_mode_latch: assert property ($fell(chip_select_n_in) |-> ##6 internal_sck_mode_out == !$past(serial_clock_in, 6))
    else $error("clock mode not taken from clock level");
  a_pullup_mode: assert property ($stable(internal_sck_mode_out) [*3] |-> serial_clock_pullup_out == internal_sck_mode_out)
    else $error("pull-up disagrees with clock mode");
  a_ext_no_drive: assert property (!internal_sck_mode_out [*3] |-> !serial_clock_oe_out)
    else $error("clock driven in external mode");
  a_abort_converts: assert property ($rose(chip_select_n_in) && xfer_r |-> ##[1:8] convert_start_out)
    else $error("no conversion after aborted transfer");
  a_phase_count: assert property ($rose(sleep_out) && starts_r != 3'h0 |-> starts_r == (autocal_en_out ? 3'h2 : 3'h1))
    else $error("wrong number of conversions per cycle");
endmodule // adc_serial_cycle_control_checker
bind adc_serial_cycle_control adc_serial_cycle_control_checker #(.CONV_TICKS(CONV_TICKS))
  i_adc_serial_cycle_control_checker (.clk_sys_in, .rst_n_in, .serial_clock_in, .serial_clock_oe_out,
  .serial_clock_pullup_out, .chip_select_n_in, .serial_out_out, .serial_out_oe_out, .autocal_en_out,
  .convert_start_out, .sleep_out, .internal_sck_mode_out);

// ### verification/adc_serial_cycle_control_tb.sv
// Self-checking bench for the converter cycle controller.
// Assumes the host model on the serial port and a shortened conversion.
`timescale 1ns/100ps
module adc_serial_cycle_control_tb;
  logic clk_sys_in = 1'b0, clk_link = 1'b0, rst_n_in = 1'b0, sdo_last = 1'b0;
  logic fclk = 1'b0, fclk_run = 1'b0;
  logic serial_in_in, chip_select_n_in, host_sck, serial_clock_out, serial_clock_oe_out;
  logic serial_clock_pullup_out, serial_out_out, serial_out_oe_out, temp_input_out, autocal_en_out;
  logic convert_start_out, sleep_out, internal_sck_mode_out;
  logic [2:0] gain_code_out;
  logic [1:0] rejection_mode_out;
  logic [18:0] res = 19'h0; // Over, under, sign, value
  logic [23:0] rx;
  int n_fail = 0, checks = 0, cyc = 0;
  // Released data line shows the inverse of its last level
  wire sck_w = serial_clock_oe_out ? serial_clock_out : host_sck;
  wire sdo_w = serial_out_oe_out ? serial_out_out : ~sdo_last;
  initial forever #5 clk_sys_in = ~clk_sys_in;
  initial #3 forever #16 clk_link = ~clk_link;
  // External conversion clock at half the system rate while enabled
  always @(negedge clk_sys_in) fclk <= fclk_run && !fclk;
  adc_serial_cycle_control #(.CONV_TICKS(4)) i_adc_serial_cycle_control (
    .clk_sys_in, .rst_n_in, .serial_clock_in(sck_w), .serial_clock_out, .serial_clock_oe_out,
    .serial_clock_pullup_out, .chip_select_n_in, .serial_in_in, .serial_out_out, .serial_out_oe_out,
    .conversion_clock_select_in(fclk), .result_value_in(res[15:0]), .result_sign_in(res[16]),
    .result_over_in(res[18]), .result_under_in(res[17]), .gain_code_out, .temp_input_out,
    .rejection_mode_out, .autocal_en_out, .convert_start_out, .sleep_out, .internal_sck_mode_out);
  adc_host_model i_adc_host_model (.clk_link_in(clk_link), .sdo_in(sdo_w), .cs_n_out(chip_select_n_in),
    .sck_out(host_sck), .sdi_out(serial_in_in));
  // ====
  // Shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_sleep();
    for (int k = 0; k < 9000 && sleep_out !== 1'b1; k++)
      @(negedge clk_sys_in);
    chk({23'h0, sleep_out}, 24'h1);
  endtask
  task automatic run_frame(input logic [7:0] cfg, input logic [18:0] r, input logic [23:0] er, input logic [7:0] ec);
    res <= r;
    wait_sleep();
    i_adc_host_model.frame(cfg, 24, rx);
    chk(rx, er);
    repeat (20) @(negedge clk_sys_in);
    chk({16'h0, internal_sck_mode_out, gain_code_out, temp_input_out, rejection_mode_out, autocal_en_out}, {16'h0, ec});
  endtask
  // ====
  // Scenarios
  task automatic t_defaults();
    repeat (10) @(negedge clk_sys_in);
    chk({16'h0, internal_sck_mode_out, gain_code_out, temp_input_out, rejection_mode_out, autocal_en_out}, 24'h81);
    chk({23'h0, serial_clock_pullup_out}, 24'h1);
  endtask
  task automatic t_config();
    run_frame(8'hd3, 19'h1a5c3, 24'h2a5c30, 8'h52);
    run_frame(8'h7f, 19'h40000, 24'h300000, 8'h52);
  endtask
  task automatic t_temp();
    run_frame(8'hfd, 19'h2ffff, 24'h1ffff0, 8'h0d);
  endtask
  task automatic t_abort();
    res <= 19'h01234;
    wait_sleep();
    res <= 19'h1beef;
    i_adc_host_model.frame(8'h00, 0, rx);
    wait_sleep();
    run_frame(8'h00, 19'h1beef, 24'h012340, 8'h0d);
  endtask
  task automatic t_mid();
    wait_sleep();
    fclk_run <= 1'b1;
    i_adc_host_model.frame(8'h00, 5, rx);
    chk(rx, 24'h000005);
    // Fast external clock ends the cycle long before the internal one would
    repeat (40) @(negedge clk_sys_in);
    chk({23'h0, sleep_out}, 24'h1);
    fclk_run <= 1'b0;
    wait_sleep();
  endtask
  task automatic t_internal();
    wait_sleep();
    i_adc_host_model.select_internal();
    // Two device clock periods: bit 21 of 2beef0 is out, clock low again
    repeat (5600) @(negedge clk_sys_in);
    chk({20'h0, serial_clock_oe_out, serial_clock_pullup_out, internal_sck_mode_out, serial_out_out},
        24'h00000f);
    i_adc_host_model.deselect();
    wait_sleep();
  endtask
  initial
  begin
    repeat (6) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    t_defaults();
    t_config();
    t_temp();
    t_abort();
    t_mid();
    t_internal();
    give_verdict();
  end
  // Ceiling well above the roughly 22000 cycles the run needs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (serial_out_oe_out)
      sdo_last <= serial_out_out;
    if (cyc == 60000)
    begin
      n_fail++;
      give_verdict();
    end
  end
endmodule // adc_serial_cycle_control_tb
